// *** lstw_defines.svh ***
// Purpose: constants of the list step trigger-wait sequencer
// Assumes: 20 MHz core clock, 50 ns period
// Notes: offsets are byte addresses on the plain register port
`ifndef LSTW_DEFINES_SVH
`define LSTW_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define LSTW_ADDR_VOL_ADD 8'h00
`define LSTW_ADDR_CUR_ADD 8'h04
`define LSTW_ADDR_DWL_ADD 8'h08
`define LSTW_ADDR_CLEAR 8'h0C
`define LSTW_ADDR_POINTS 8'h10
`define LSTW_ADDR_SWEEP 8'h14
`define LSTW_ADDR_WAIT_TMO 8'h18
`define LSTW_ADDR_WAIT_CMD 8'h1C
`define LSTW_ADDR_LEVEL 8'h20
`define LSTW_ADDR_LEVEL_MAX 8'h24
`define LSTW_ADDR_LEVEL_MIN 8'h28
`define LSTW_ADDR_ERR 8'h2C
`define LSTW_ADDR_STATUS 8'h30
`define LSTW_ADDR_STEPS 8'h34
// ****************************************
// Fields, codes and reset values
// ****************************************
`define LSTW_WAIT_TYPE_LSB 16
`define LSTW_WAIT_HIGH 2'h1
`define LSTW_WAIT_LOW 2'h2
`define LSTW_WAIT_FALL 2'h3
`define LSTW_ERR_CONFLICT 16'hFF23
`define LSTW_ERR_RANGE 16'hFF22
`define LSTW_ERR_NOT_SAME 16'hFF1E
`define LSTW_ERR_UNBAL 16'hFF14
`define LSTW_ERRQ_DEPTH 4
`define LSTW_ANGLE_MIN 16'h0001
`define LSTW_ANGLE_FULL 16'h8CA0
`define LSTW_TMO_MIN_US 16'h00FA
`define LSTW_TMO_MAX_US 16'h84D0
`define LSTW_LEVEL_MAX_DEF 16'h2710
// ****************************************
// Timing
// ****************************************
`define LSTW_CLK_NS 50
`define LSTW_HIGH_STABLE_NS 400000
`define LSTW_LOW_STABLE_NS 2000
`define LSTW_HIGH_CYC ((`LSTW_HIGH_STABLE_NS + `LSTW_CLK_NS - 1) / `LSTW_CLK_NS)
`define LSTW_LOW_CYC ((`LSTW_LOW_STABLE_NS + `LSTW_CLK_NS - 1) / `LSTW_CLK_NS)
`define LSTW_CYC_PER_US (1000 / `LSTW_CLK_NS)
`endif

// *** lstw_pkg.sv ***
// Purpose: types of the list step trigger-wait sequencer
// Assumes: lstw_defines.svh on the include path
// Notes: whole block state is one packed struct
`include "lstw_defines.svh"
package lstw_pkg;
  // ****************************************
  // Wait step states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HIGH = 5'h02,
    ST_LOW = 5'h04,
    ST_ARM = 5'h08,
    ST_FALL = 5'h10
  } lstw_state_t;
  // ****************************************
  // Block state
  // ****************************************
  typedef struct packed {
    lstw_state_t st;
    logic [1:0] sync;
    logic [1:0] filt;
    logic [1:0][15:0] fcnt;
    logic [15:0] volCnt;
    logic [15:0] curCnt;
    logic [15:0] dwlCnt;
    logic [15:0] swStart;
    logic [15:0] swStop;
    logic [15:0] tmoUs;
    logic [19:0] tmoCnt;
    logic [15:0] setpt;
    logic [15:0] stepCnt;
    logic [`LSTW_ERRQ_DEPTH-1:0][15:0] errQ;
    logic [2:0] errCnt;
    logic [31:0] rdata;
    logic stepP;
  } lstw_regs_t;
endpackage : lstw_pkg

// *** lstw_sequencer.sv ***
// Purpose: step-advance controller of an output-level list sequencer
// Assumes: trigger input asynchronous, all else synchronous to core_clk
// Notes: list contents live elsewhere; only counts are kept here
// How it works
// - Sweep stop angle defaults to 360 degrees when only start given.
// - Sweep query returns start then stop angle, each 0.01 to 360.
// - List clear puts the fill pointer back to location 0.
// - Each stored entry bumps the pointer; point query returns it.
// - Point query with current entries present posts error -221.
// - A wait step sets the output setpoint at once, before waiting.
// - Wait-high with input already high and timeout set skips immediately.
// - Wait-high with input low advances on high or timeout, first wins.
// - Zero timeout makes wait-high hold until input goes high.
// - Wait-high accepts a level stable 0.4 ms; driver holds that long.
// - Wait step with empty lists is rejected with error -221.
// - High or falling-edge wait with dwell length mismatch posts -226.
// - Wait-low with dwell length mismatch posts error -236.
// - Falling-edge wait ignores an initial low; needs rise then fall.
// - Falling-edge wait with timeout advances on fall or timeout.
// - Zero timeout makes falling-edge wait hold until a fall.
// - Wait-low with input already low and timeout set skips immediately.
// - Wait-low advances on low or timeout; zero timeout waits forever.
// - Wait-low accepts a level stable 2 us; driver holds that long.
// - Setpoint above the model maximum is rejected with error -222.
// - Level query gives setpoint, maximum option, or negative minimum.
// - Wait timeout spans 0.00025 to 0.034 s; zero means infinite.
`timescale 1ns/1ps
`include "lstw_defines.svh"
module lstw_sequencer #(
  parameter int unsigned HIGH_CYC = `LSTW_HIGH_CYC,
  parameter int unsigned LOW_CYC = `LSTW_LOW_CYC,
  parameter logic signed [15:0] LEVEL_MAX = `LSTW_LEVEL_MAX_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdata,
  input wire logic trigIn,
  output logic [15:0] levelOut,
  output logic stepPulse,
  output logic busy
);
  // ****************************************
  // State and reset image
  // ****************************************
  // Synchroniser and filters start at the idle-high level of an open
  // trigger input, so leaving reset never looks like a level change
  localparam lstw_pkg::lstw_regs_t RST_VAL = '{
    st: lstw_pkg::ST_IDLE,
    sync: 2'h3,
    filt: 2'h3,
    swStart: `LSTW_ANGLE_MIN,
    swStop: `LSTW_ANGLE_FULL,
    default: '0
  };
  // Current state and its next value
  lstw_pkg::lstw_regs_t r;
  lstw_pkg::lstw_regs_t n;
  // Error posted this cycle and its code
  logic errPost;
  logic [15:0] errCode;
  // Decoded views of the bus and the timeout
  logic signed [15:0] wLevel;
  logic [1:0] wType;
  logic [19:0] tmoLim;
  logic tmoHit;
  logic [15:0] lvlLen;
  logic [15:0] onesCnt;

  // ****************************************
  // Outputs and operand views
  // ****************************************
  // Outputs straight from the state register; busy is a decode of the
  // one-hot state, so it rises in the cycle after the accepted command
  assign rdata = r.rdata;
  assign levelOut = r.setpt;
  assign stepPulse = r.stepP;
  assign busy = (r.st != lstw_pkg::ST_IDLE);

  // Operand views of the write data
  // Level list length adds both types; conflict checks keep one empty
  assign wLevel = $signed(wdata[15:0]);
  assign wType = wdata[`LSTW_WAIT_TYPE_LSB +: 2];
  assign lvlLen = r.volCnt + r.curCnt;
  assign onesCnt = 16'h0001;

  // Zero timeout never expires, so the wait is infinite. The limit is
  // counted in waiting cycles from the cycle after the step started;
  // the largest setting fits the 20-bit counter with room to spare
  assign tmoLim = 20'(r.tmoUs * `LSTW_CYC_PER_US);
  assign tmoHit = (r.tmoUs != 16'h0000) && (r.tmoCnt >= tmoLim - 20'h00001);

  // ****************************************
  // Next-state logic
  // ****************************************
  // One next-state process; every field but stepP and rdata holds unless a branch moves it; those two default to zero
  always_comb begin
    n = r;
    errPost = 1'b0;
    errCode = 16'h0000;
    n.stepP = 1'b0;
    n.rdata = 32'h00000000;

    // ****************************************
    // Trigger synchroniser and level filters
    // ****************************************
    // Two-stage synchroniser; only the second stage feeds the filters
    n.sync = {r.sync[0], trigIn};
    // Filter 0 needs 0.4 ms of stable level, filter 1 needs 2 us.
    // A filter counts samples that differ from its output and restarts on
    // any agreeing sample, so a glitch shorter than the window is lost
    for (int i = 0; i < 2; i++) begin
      if (r.sync[1] == r.filt[i]) begin
        n.fcnt[i] = 16'h0000;
      end else if (32'(r.fcnt[i]) >= ((i == 0) ? HIGH_CYC : LOW_CYC) - 1) begin
        n.filt[i] = r.sync[1];
        n.fcnt[i] = 16'h0000;
      end else begin
        n.fcnt[i] = r.fcnt[i] + onesCnt;
      end
    end

    // ****************************************
    // Wait step sequencing
    // ****************************************
    // The filters settle from the input, not the step, so a level that is
    // already valid when a step starts ends it in the next cycle
    case (r.st)
      lstw_pkg::ST_HIGH: begin
        // Slow filter decides; the timeout counts only when nonzero
        if (r.filt[0]) begin
          n.st = lstw_pkg::ST_IDLE;
        end else if (tmoHit) begin
          n.st = lstw_pkg::ST_IDLE;
        end else begin
          n.tmoCnt = r.tmoCnt + 20'h00001;
        end
      end
      lstw_pkg::ST_LOW: begin
        // Fast filter decides; the timeout counts only when nonzero
        if (!r.filt[1]) begin
          n.st = lstw_pkg::ST_IDLE;
        end else if (tmoHit) begin
          n.st = lstw_pkg::ST_IDLE;
        end else begin
          n.tmoCnt = r.tmoCnt + 20'h00001;
        end
      end
      lstw_pkg::ST_ARM: begin
        // A low already present must first rise
        if (tmoHit) begin
          n.st = lstw_pkg::ST_IDLE;
        end else begin
          n.tmoCnt = r.tmoCnt + 20'h00001;
          if (r.filt[1]) begin
            n.st = lstw_pkg::ST_FALL;
          end
        end
      end
      lstw_pkg::ST_FALL: begin
        // Armed: the fall of the fast filter is the accepted edge
        if (!r.filt[1]) begin
          n.st = lstw_pkg::ST_IDLE;
        end else if (tmoHit) begin
          n.st = lstw_pkg::ST_IDLE;
        end else begin
          n.tmoCnt = r.tmoCnt + 20'h00001;
        end
      end
      default: begin
        // Idle and any illegal code rest in idle
        n.st = lstw_pkg::ST_IDLE;
      end
    endcase
    // Step done: pulse and count
    if (busy && (n.st == lstw_pkg::ST_IDLE)) begin
      n.stepP = 1'b1;
      n.stepCnt = r.stepCnt + onesCnt;
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Writes act at the strobed edge; bad values only post an error
    if (wrStb) begin
      if (addr == `LSTW_ADDR_VOL_ADD) begin
        // Voltage entry: type conflict first, then range
        if (r.curCnt != 16'h0000) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_CONFLICT;
        end else if (wLevel > LEVEL_MAX || wLevel < -LEVEL_MAX) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_RANGE;
        end else begin
          n.volCnt = r.volCnt + onesCnt;
        end
      end else if (addr == `LSTW_ADDR_CUR_ADD) begin
        // Current entry refused while voltage entries exist
        if (r.volCnt != 16'h0000) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_CONFLICT;
        end else begin
          n.curCnt = r.curCnt + onesCnt;
        end
      end else if (addr == `LSTW_ADDR_DWL_ADD) begin
        // Dwell entries are only counted, to balance the step checks
        n.dwlCnt = r.dwlCnt + onesCnt;
      end else if (addr == `LSTW_ADDR_CLEAR) begin
        // Clear rewinds every fill pointer to location 0
        n.volCnt = 16'h0000;
        n.curCnt = 16'h0000;
        n.dwlCnt = 16'h0000;
      end else if (addr == `LSTW_ADDR_SWEEP) begin
        // Missing stop angle means a full turn
        n.swStop = (wdata[31:16] == 16'h0000) ? `LSTW_ANGLE_FULL : wdata[31:16];
        n.swStart = wdata[15:0];
        // A bad field leaves both angles as they were
        if (wdata[15:0] < `LSTW_ANGLE_MIN || wdata[15:0] > `LSTW_ANGLE_FULL
            || wdata[31:16] > `LSTW_ANGLE_FULL) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_RANGE;
          n.swStart = r.swStart;
          n.swStop = r.swStop;
        end
      end else if (addr == `LSTW_ADDR_WAIT_TMO) begin
        // Timeout in microseconds; zero is allowed and means no limit
        if (wdata[15:0] != 16'h0000 && (wdata[15:0] < `LSTW_TMO_MIN_US
            || wdata[15:0] > `LSTW_TMO_MAX_US)) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_RANGE;
        end else begin
          n.tmoUs = wdata[15:0];
        end
      end else if (addr == `LSTW_ADDR_LEVEL) begin
        // Direct setpoint write, range checked like voltage entries
        if (wLevel > LEVEL_MAX || wLevel < -LEVEL_MAX) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_RANGE;
        end else begin
          n.setpt = wdata[15:0];
        end
      end else if (addr == `LSTW_ADDR_WAIT_CMD) begin
        // A step issued while one runs, or with wait type 0, is dropped
        // Otherwise checks run in a fixed order and only the first posts
        if (busy || wType == 2'h0) begin
          errPost = 1'b0;
        end else if (lvlLen == 16'h0000) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_CONFLICT;
        end else if (wLevel > LEVEL_MAX || wLevel < -LEVEL_MAX) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_RANGE;
        end else if (r.dwlCnt != lvlLen) begin
          errPost = 1'b1;
          errCode = (wType == `LSTW_WAIT_LOW) ? `LSTW_ERR_UNBAL
                                              : `LSTW_ERR_NOT_SAME;
        end else begin
          // Accepted: setpoint moves now and the timeout restarts
          n.setpt = wdata[15:0];
          n.tmoCnt = 20'h00000;
          if (wType == `LSTW_WAIT_HIGH) begin
            n.st = lstw_pkg::ST_HIGH;
          end else if (wType == `LSTW_WAIT_LOW) begin
            n.st = lstw_pkg::ST_LOW;
          end else begin
            n.st = lstw_pkg::ST_ARM;
          end
        end
      end
    end

    // ****************************************
    // Register reads, data valid next cycle
    // ****************************************
    // Reads are registered: data stand one cycle, then return to zero
    if (rdStb) begin
      if (addr == `LSTW_ADDR_POINTS) begin
        // Pointer equals the entry count and the next free location
        n.rdata = {16'h0000, lvlLen};
        if (r.curCnt != 16'h0000) begin
          errPost = 1'b1;
          errCode = `LSTW_ERR_CONFLICT;
        end
      end else if (addr == `LSTW_ADDR_SWEEP) begin
        // Stop angle in the upper half, start in the lower
        n.rdata = {r.swStop, r.swStart};
      end else if (addr == `LSTW_ADDR_WAIT_TMO) begin
        // Reads zero until a timeout has been set
        n.rdata = {16'h0000, r.tmoUs};
      end else if (addr == `LSTW_ADDR_LEVEL) begin
        // Signed setpoint, sign-extended to the bus
        n.rdata = {{16{r.setpt[15]}}, r.setpt};
      end else if (addr == `LSTW_ADDR_LEVEL_MAX) begin
        // Model limits; the minimum is the negated maximum
        n.rdata = 32'(LEVEL_MAX);
      end else if (addr == `LSTW_ADDR_LEVEL_MIN) begin
        n.rdata = 32'(-LEVEL_MAX);
      end else if (addr == `LSTW_ADDR_ERR) begin
        // Oldest error pops; empty queue reads zero
        if (r.errCnt != 3'h0) begin
          n.rdata = {{16{r.errQ[0][15]}}, r.errQ[0]};
          for (int k = 0; k < `LSTW_ERRQ_DEPTH - 1; k++) begin
            n.errQ[k] = r.errQ[k + 1];
          end
          n.errQ[`LSTW_ERRQ_DEPTH - 1] = 16'h0000;
          n.errCnt = r.errCnt - 3'h1;
        end
      end else if (addr == `LSTW_ADDR_STATUS) begin
        // State, queue fill and both filtered levels, for debug
        n.rdata = {24'h000000, r.errCnt, r.st};
        n.rdata[31:30] = r.filt;
      end else if (addr == `LSTW_ADDR_STEPS) begin
        // Completed steps; the count wraps at 16 bits
        n.rdata = {16'h0000, r.stepCnt};
      end else begin
        // Unmapped reads return zero
        n.rdata = 32'h00000000;
      end
    end

    // ****************************************
    // Error queue push
    // ****************************************
    // Error push after any pop; a full queue drops the newest.
    // Pushing after the pop lets a read and a new error share a cycle
    if (errPost && (32'(n.errCnt) < `LSTW_ERRQ_DEPTH)) begin
      n.errQ[n.errCnt[1:0]] = errCode;
      n.errCnt = n.errCnt + 3'h1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // State register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end
endmodule : lstw_sequencer

// *** lstw_sequencer_properties.sv ***
// Purpose: port checks of the sequencer
// Assumes: one clock domain, reset synchronous
// Notes: bound to every instance of the sequencer
`timescale 1ns/1ps
`include "lstw_defines.svh"
module lstw_seq_checker #(
  parameter logic signed [15:0] LEVEL_MAX = 16'h2710
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdata,
  input wire logic trigIn,
  input wire logic [15:0] levelOut,
  input wire logic stepPulse,
  input wire logic busy
);
  localparam logic signed [15:0] LvlMin = -LEVEL_MAX;
  logic [15:0] wLvl;
  // Level field of the write data
  assign wLvl = wdata[15:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************
  // Step sequences
  // ****************
  sequence s_wait_cmd;
    wrStb && addr == `LSTW_ADDR_WAIT_CMD;
  endsequence
  sequence s_step_start;
    s_wait_cmd ##1 $rose(busy);
  endsequence
  a_rdata_idle: assert property (!rdStb |=> rdata == 32'h0)
    else $error("read data not idle");
  a_pulse_single: assert property (stepPulse |=> !stepPulse)
    else $error("step pulse too long");
  a_pulse_ends_busy: assert property (stepPulse |-> !busy && $past(busy))
    else $error("step pulse without step end");
  a_level_at_start: assert property (s_step_start |-> levelOut == $past(wLvl))
    else $error("level not set at step start");
  a_busy_cause: assert property ($rose(busy) |-> $past(wrStb))
    else $error("step started without command");
  a_level_hold: assert property (busy && $past(busy) && !$past(wrStb) |-> $stable(levelOut))
    else $error("level moved during step");
  a_max_read: assert property (rdStb && addr == `LSTW_ADDR_LEVEL_MAX
    |=> rdata == {{16{LEVEL_MAX[15]}}, LEVEL_MAX}) else $error("maximum read wrong");
  a_min_read: assert property (rdStb && addr == `LSTW_ADDR_LEVEL_MIN
    |=> rdata == {{16{LvlMin[15]}}, LvlMin} && rdata[31]) else $error("minimum read wrong");
endmodule : lstw_seq_checker
bind lstw_sequencer lstw_seq_checker #(.LEVEL_MAX(LEVEL_MAX)) chk (.core_clk(core_clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
  .trigIn(trigIn), .levelOut(levelOut), .stepPulse(stepPulse), .busy(busy));

// *** lstw_sequencer_tb.sv ***
// Purpose: self-checking bench of the sequencer
// Assumes: filters shortened to 20 and 4 cycles
// Notes: error codes read back sign-extended
`timescale 1ns/1ps
`include "lstw_defines.svh"
module lstw_sequencer_tb;
  localparam int HC = 20;
  localparam int LC = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic lvlReq = 1'b1;
  logic trigIn;
  logic [31:0] rdata;
  logic [15:0] levelOut;
  logic stepPulse;
  logic busy;
  int failures = 0;
  int numChecks = 0;
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  lstw_sequencer #(.HIGH_CYC(HC), .LOW_CYC(LC)) uut (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
    .trigIn(trigIn), .levelOut(levelOut), .stepPulse(stepPulse), .busy(busy));
  lstw_trig_host #(.MIN_HOLD(HC)) host (.core_clk(core_clk), .lvlReq(lvlReq),
    .trigIn(trigIn));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1;
    check(nm, rdata, exp);
  endtask : rdc
  // Bounded wait for the step pulse, judged against a cycle window
  task automatic stepc(input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (stepPulse !== 1'b1 && n <= hi) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(nm, 32'(n >= lo && n <= hi), 32'h1);
    if (n > hi) give_verdict();
  endtask : stepc
  task automatic setTrig(input logic v);
    @(posedge core_clk);
    lvlReq <= v;
    repeat (3 * HC) @(posedge core_clk);
    #1;
  endtask : setTrig
  // ****************
  // Scenarios
  // ****************
  task automatic t_angles;
    rdc(`LSTW_ADDR_SWEEP, 32'h8CA0_0001, "sweep reset");
    wr(`LSTW_ADDR_SWEEP, 32'h0000_2328);
    rdc(`LSTW_ADDR_SWEEP, 32'h8CA0_2328, "sweep stop default");
    wr(`LSTW_ADDR_SWEEP, 32'h8CA1_0001);
    rdc(`LSTW_ADDR_ERR, -32'h0000_00DE, "sweep range");
    rdc(`LSTW_ADDR_WAIT_TMO, 32'h0, "timeout reset");
    wr(`LSTW_ADDR_WAIT_TMO, 32'h0000_00F9);
    rdc(`LSTW_ADDR_ERR, -32'h0000_00DE, "timeout range");
  endtask : t_angles
  task automatic t_lists;
    wr(`LSTW_ADDR_CLEAR, 32'h0);
    repeat (3) wr(`LSTW_ADDR_VOL_ADD, 32'h0);
    rdc(`LSTW_ADDR_POINTS, 32'h3, "points");
    wr(`LSTW_ADDR_CLEAR, 32'h0);
    rdc(`LSTW_ADDR_POINTS, 32'h0, "points clear");
    wr(`LSTW_ADDR_CUR_ADD, 32'h0);
    rdc(`LSTW_ADDR_POINTS, 32'h1, "points current");
    rdc(`LSTW_ADDR_ERR, -32'h0000_00DD, "points conflict");
  endtask : t_lists
  task automatic t_errors;
    wr(`LSTW_ADDR_CLEAR, 32'h0);
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0001_0055);
    rdc(`LSTW_ADDR_ERR, -32'h0000_00DD, "empty list");
    check("level kept", {16'h0, levelOut}, 32'h0);
    wr(`LSTW_ADDR_VOL_ADD, 32'h0);
    for (int t = 1; t < 4; t++) begin
      wr(`LSTW_ADDR_WAIT_CMD, {14'h0, t[1:0], 16'h0});
      rdc(`LSTW_ADDR_ERR, (t == 2) ? -32'h0000_00EC : -32'h0000_00E2, "dwell");
    end
    wr(`LSTW_ADDR_LEVEL, 32'h0000_2711);
    rdc(`LSTW_ADDR_ERR, -32'h0000_00DE, "level range");
    wr(`LSTW_ADDR_LEVEL, 32'h0000_2710);
    rdc(`LSTW_ADDR_LEVEL, 32'h0000_2710, "level");
    rdc(`LSTW_ADDR_LEVEL_MAX, 32'h0000_2710, "max");
    rdc(`LSTW_ADDR_LEVEL_MIN, 32'hFFFF_D8F0, "min");
    wr(`LSTW_ADDR_DWL_ADD, 32'h0);
  endtask : t_errors
  task automatic t_high;
    setTrig(1'b0);
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0001_0123);
    check("step level", {16'h0, levelOut}, 32'h0000_0123);
    repeat (200) @(posedge core_clk);
    #1;
    check("high hold", {31'h0, busy}, 32'h1);
    rdc(`LSTW_ADDR_STATUS, 32'h0000_0002, "high state");
    @(posedge core_clk);
    lvlReq <= 1'b1;
    stepc(HC, HC + 8, "high advance");
  endtask : t_high
  task automatic t_skip;
    setTrig(1'b1);
    wr(`LSTW_ADDR_WAIT_TMO, 32'h0000_00FA);
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0001_0000);
    stepc(0, 3, "high skip");
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0002_0000);
    stepc(5000, 5004, "low timeout");
    setTrig(1'b0);
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0002_0000);
    stepc(0, 3, "low skip");
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0003_0000);
    stepc(5000, 5004, "edge timeout");
  endtask : t_skip
  task automatic t_fall;
    wr(`LSTW_ADDR_WAIT_TMO, 32'h0);
    wr(`LSTW_ADDR_WAIT_CMD, 32'h0003_0000);
    setTrig(1'b1);
    check("edge hold", {31'h0, busy}, 32'h1);
    @(posedge core_clk);
    lvlReq <= 1'b0;
    stepc(LC, LC + 8, "edge advance");
    rdc(`LSTW_ADDR_STEPS, 32'h0000_0006, "step count");
  endtask : t_fall
  task automatic give_verdict;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_angles();
    t_lists();
    t_errors();
    t_high();
    t_skip();
    t_fall();
    give_verdict();
  end
endmodule : lstw_sequencer_tb

// *** lstw_trig_host.sv ***
// Purpose: host computer driving the trigger level
// Assumes: lvlReq is set by the bench at clock edges
// Notes: a new level waits until the old one was held long enough
`timescale 1ns/1ps
module lstw_trig_host #(
  parameter int unsigned MIN_HOLD = 20
) (
  input wire logic core_clk,
  input wire logic lvlReq,
  output logic trigIn
);
  int unsigned holdCnt_r = 0;
  // Open circuit reads high until the host drives low
  logic level_r = 1'b1;
  assign trigIn = level_r;
  // Short pulses would be filtered away, so the host never makes them
  always @(posedge core_clk) begin
    if (lvlReq != level_r && holdCnt_r >= MIN_HOLD) begin
      level_r <= lvlReq;
      holdCnt_r <= 0;
    end else if (holdCnt_r < MIN_HOLD) begin
      holdCnt_r <= holdCnt_r + 1;
    end
  end
endmodule : lstw_trig_host
